// File: src/psm_pkg.sv
package psm_pkg;
  // Modulation mode select encoding
  localparam logic [1:0] MODE_BPSK = 2'h0;
  localparam logic [1:0] MODE_PI2_BPSK = 2'h1;
  localparam logic [1:0] MODE_QPSK = 2'h2;
  localparam logic [1:0] MODE_PI4_QPSK = 2'h3;
  // Default output width and fraction bits (Q1.(W-2) style)
  localparam int OUT_W = 16;
  // Bits per symbol
  localparam logic [1:0] BITS_ONE = 2'h1;
  localparam logic [1:0] BITS_TWO = 2'h2;
  // Constellation level selectors
  typedef enum logic [2:0] {
    PSM_LVL_ZERO = 3'h0,
    PSM_LVL_POS_ONE = 3'h1,
    PSM_LVL_NEG_ONE = 3'h2,
    PSM_LVL_POS_DIAG = 3'h3,
    PSM_LVL_NEG_DIAG = 3'h4
  } psm_lvl_t;
endpackage

// File: src/psm_level.sv
`timescale 1ns/1ns
`default_nettype none
// Converts a level selector to a signed fixed-point value, unity = 2^(W-2)
module psm_level #(
  parameter int W = psm_pkg::OUT_W
) (
  input wire psm_pkg::psm_lvl_t lvl_i,
  output logic signed [W-1:0] val_o
);
  localparam logic signed [W-1:0] ONE = W'(1) <<< (W - 2);
  // 1/sqrt2 scaled by unity; the integer cast already rounds to nearest
  localparam logic signed [W-1:0] DIAG = W'(longint'(0.70710678 * (2.0 ** (W - 2))));
  always_comb begin
    unique case (lvl_i)
      psm_pkg::PSM_LVL_POS_ONE: val_o = ONE;
      psm_pkg::PSM_LVL_NEG_ONE: val_o = -ONE;
      psm_pkg::PSM_LVL_POS_DIAG: val_o = DIAG;
      psm_pkg::PSM_LVL_NEG_DIAG: val_o = -DIAG;
      default: val_o = '0;
    endcase
  end
endmodule
`default_nettype wire

// File: src/psm_mapper.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - BPSK takes one input bit for every output symbol
// - pi/2-BPSK one bit per symbol, alternating even then odd tables
// - Even pi/2-BPSK: one gives (1,0), zero gives (-1,0)
// - Odd pi/2-BPSK: one gives (0,-1), zero gives (0,1)
// - QPSK pairs consecutive bits, earlier bit first, later bit second
// - QPSK I follows first bit, Q second bit, as +-1/sqrt2
// - pi/4-QPSK takes four bits: first pair even symbol, second pair odd
// - Even pi/4-QPSK uses the diagonal points driven by the two bits
// - Odd pi/4-QPSK: 11 (1,0), 10 (0,-1), 01 (0,1), 00 (-1,0)
module psm_mapper #(
  parameter int W = psm_pkg::OUT_W
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] MODE_I,
  input wire logic BIT_I,
  input wire logic BIT_VALID_I,
  output logic BIT_READY_O,
  output logic signed [W-1:0] I_O,
  output logic signed [W-1:0] Q_O,
  output logic SYM_VALID_O,
  output logic SYM_ODD_O
);
  typedef enum logic [1:0] {
    PSM_ST_FIRST = 2'b01,
    PSM_ST_SECOND = 2'b10
  } psm_st_t;

  typedef struct packed {
    psm_st_t st;
    logic first_symbol_bit;
    logic odd;
    psm_pkg::psm_lvl_t lvl_i;
    psm_pkg::psm_lvl_t lvl_q;
    logic valid;
    logic sym_odd;
  } psm_state_t;

  psm_state_t s_r;
  psm_state_t s_nxt;
  logic signed [W-1:0] in_phase_value;
  logic signed [W-1:0] quadrature_value;

  function automatic psm_pkg::psm_lvl_t axis(input logic b);
    axis = b ? psm_pkg::PSM_LVL_POS_ONE : psm_pkg::PSM_LVL_NEG_ONE;
  endfunction

  function automatic psm_pkg::psm_lvl_t diag(input logic b);
    diag = b ? psm_pkg::PSM_LVL_POS_DIAG : psm_pkg::PSM_LVL_NEG_DIAG;
  endfunction

  // Mapper always accepts; the modulator is assumed to take one symbol per cycle
  assign BIT_READY_O = 1'b1;

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.sym_odd = 1'b0;
    if (BIT_VALID_I) begin
      unique case (MODE_I)
        psm_pkg::MODE_BPSK: begin
          s_nxt.lvl_i = axis(BIT_I);
          s_nxt.lvl_q = psm_pkg::PSM_LVL_ZERO;
          s_nxt.odd = 1'b0;
          s_nxt.valid = 1'b1;
        end
        psm_pkg::MODE_PI2_BPSK: begin
          if (!s_r.odd) begin
            s_nxt.lvl_i = axis(BIT_I);
            s_nxt.lvl_q = psm_pkg::PSM_LVL_ZERO;
          end else begin
            s_nxt.lvl_i = psm_pkg::PSM_LVL_ZERO;
            s_nxt.lvl_q = axis(!BIT_I);
          end
          s_nxt.sym_odd = s_r.odd;
          s_nxt.odd = !s_r.odd;
          s_nxt.valid = 1'b1;
        end
        default: begin
          // Two-bit modes share the pairing state machine
          unique case (s_r.st)
            PSM_ST_FIRST: begin
              s_nxt.first_symbol_bit = BIT_I;
              s_nxt.st = PSM_ST_SECOND;
            end
            PSM_ST_SECOND: begin
              s_nxt.st = PSM_ST_FIRST;
              s_nxt.valid = 1'b1;
              if (MODE_I == psm_pkg::MODE_QPSK || !s_r.odd) begin
                s_nxt.lvl_i = diag(s_r.first_symbol_bit);
                s_nxt.lvl_q = diag(BIT_I);
              end else begin
                unique case ({s_r.first_symbol_bit, BIT_I})
                  2'h3: begin
                    s_nxt.lvl_i = psm_pkg::PSM_LVL_POS_ONE;
                    s_nxt.lvl_q = psm_pkg::PSM_LVL_ZERO;
                  end
                  2'h2: begin
                    s_nxt.lvl_i = psm_pkg::PSM_LVL_ZERO;
                    s_nxt.lvl_q = psm_pkg::PSM_LVL_NEG_ONE;
                  end
                  2'h1: begin
                    s_nxt.lvl_i = psm_pkg::PSM_LVL_ZERO;
                    s_nxt.lvl_q = psm_pkg::PSM_LVL_POS_ONE;
                  end
                  2'h0: begin
                    s_nxt.lvl_i = psm_pkg::PSM_LVL_NEG_ONE;
                    s_nxt.lvl_q = psm_pkg::PSM_LVL_ZERO;
                  end
                endcase
              end
              s_nxt.odd = (MODE_I == psm_pkg::MODE_PI4_QPSK) ? !s_r.odd : 1'b0;
              s_nxt.sym_odd = (MODE_I == psm_pkg::MODE_PI4_QPSK) && s_r.odd;
            end
            default: s_nxt.st = PSM_ST_FIRST;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '{st: PSM_ST_FIRST, first_symbol_bit: 1'b0, odd: 1'b0,
               lvl_i: psm_pkg::PSM_LVL_ZERO, lvl_q: psm_pkg::PSM_LVL_ZERO,
               valid: 1'b0, sym_odd: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  psm_level #(.W(W)) u_lvl_i (.lvl_i(s_r.lvl_i), .val_o(in_phase_value));
  psm_level #(.W(W)) u_lvl_q (.lvl_i(s_r.lvl_q), .val_o(quadrature_value));

  // Decode is from registered selectors only, so outputs stay glitch-free
  assign I_O = in_phase_value;
  assign Q_O = quadrature_value;
  assign SYM_VALID_O = s_r.valid;
  // Registered so the flag cannot glitch when the mode input moves
  assign SYM_ODD_O = s_r.sym_odd;

  bpsk_one_bit_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_BPSK) |=> SYM_VALID_O)
    else $error("BPSK bit gave no symbol");
  bpsk_map_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_BPSK) |=>
      (Q_O == 0 && (I_O > 0) == $past(BIT_I)))
    else $error("BPSK mapping wrong");
  pi2_alt_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI2_BPSK) |=> (s_r.odd != $past(s_r.odd)))
    else $error("pi/2 parity did not alternate");
  pi2_even_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI2_BPSK && !s_r.odd) |=>
      (Q_O == 0 && (I_O > 0) == $past(BIT_I)))
    else $error("pi/2 even mapping wrong");
  pi2_odd_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI2_BPSK && s_r.odd) |=>
      (I_O == 0 && (Q_O < 0) == $past(BIT_I)))
    else $error("pi/2 odd mapping wrong");
  qpsk_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_QPSK && s_r.st == PSM_ST_FIRST) |=> !SYM_VALID_O)
    else $error("QPSK emitted after one bit");
  qpsk_map_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_QPSK && s_r.st == PSM_ST_SECOND) |=>
      ((I_O > 0) == $past(s_r.first_symbol_bit) && (Q_O > 0) == $past(BIT_I) && I_O != 0))
    else $error("QPSK mapping wrong");
  pi4_odd_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI4_QPSK && s_r.st == PSM_ST_SECOND
     && s_r.odd) |=> ((I_O == 0) != (Q_O == 0)))
    else $error("pi/4 odd symbol not axial");
  // Sign tests keep these checks independent of the output width
  pi4_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI4_QPSK && s_r.st == PSM_ST_FIRST)
      |=> !SYM_VALID_O)
    else $error("pi/4 emitted after one bit");
  pi4_alt_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI4_QPSK && s_r.st == PSM_ST_SECOND)
      |=> (s_r.odd != $past(s_r.odd) && SYM_ODD_O == $past(s_r.odd)))
    else $error("pi/4 parity did not alternate");
  pi4_even_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI4_QPSK && s_r.st == PSM_ST_SECOND
     && !s_r.odd) |=> (I_O != 0 && (I_O == Q_O || I_O == -Q_O)
      && (I_O > 0) == $past(s_r.first_symbol_bit) && (Q_O > 0) == $past(BIT_I)))
    else $error("pi/4 even mapping wrong");
  pi4_odd_map_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI4_QPSK && s_r.st == PSM_ST_SECOND
     && s_r.odd) |=>
      ((I_O > 0) == ($past(s_r.first_symbol_bit) && $past(BIT_I))
      && (I_O < 0) == (!$past(s_r.first_symbol_bit) && !$past(BIT_I))
      && (Q_O < 0) == ($past(s_r.first_symbol_bit) && !$past(BIT_I))
      && (Q_O > 0) == (!$past(s_r.first_symbol_bit) && $past(BIT_I))))
    else $error("pi/4 odd mapping wrong");
  pi2_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_PI2_BPSK) |=> (SYM_ODD_O == $past(s_r.odd)))
    else $error("pi/2 odd flag wrong");
  odd_flag_qual_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    SYM_ODD_O |-> SYM_VALID_O)
    else $error("odd flag without symbol");
  valid_source_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    SYM_VALID_O |-> $past(BIT_VALID_I))
    else $error("symbol without a taken bit");
  out_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !BIT_VALID_I |=> (!SYM_VALID_O && $stable(I_O) && $stable(Q_O)))
    else $error("outputs moved without a bit");
  rst_state_a: assert property (@(posedge SYS_CLK_I)
    RST_I |=> (!SYM_VALID_O && !SYM_ODD_O && I_O == 0 && Q_O == 0
      && !s_r.odd && s_r.st == PSM_ST_FIRST))
    else $error("reset did not restart the mapper");
  state_onehot_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $onehot(s_r.st))
    else $error("pairing state not one-hot");
  qpsk_parity_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_QPSK && s_r.st == PSM_ST_SECOND)
      |=> (!s_r.odd && !SYM_ODD_O && (I_O == Q_O || I_O == -Q_O)))
    else $error("QPSK symbol off the diagonal");
  bpsk_parity_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BIT_VALID_I && MODE_I == psm_pkg::MODE_BPSK) |=> (!s_r.odd && !SYM_ODD_O))
    else $error("BPSK symbol marked odd");
endmodule
`default_nettype wire

// File: sim/psm_src.sv
`timescale 1ns/1ns
`default_nettype none
// Upstream bit source, oldest bit first
module psm_src (
  input wire logic clk_i,
  output logic bit_o,
  output logic valid_o
);
  initial begin
    bit_o = 1'b0;
    valid_o = 1'b0;
  end
  task automatic send(input logic [15:0] b, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(negedge clk_i);
      bit_o = b[k];
      valid_o = 1'b1;
    end
    @(negedge clk_i);
    valid_o = 1'b0;
    // Stale data flipped so a sticky bit is not mistaken for a fresh one
    bit_o = ~bit_o;
  endtask
endmodule
`default_nettype wire

// File: sim/psm_mapper_tb.sv
`timescale 1ns/1ns
`default_nettype none
module psm_mapper_tb;
  localparam logic signed [15:0] U = 16'sh4000;
  localparam logic signed [15:0] D = 16'sh2d41;
  localparam logic signed [15:0] Z = 16'sh0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = psm_pkg::MODE_BPSK;
  logic bit_d, bit_v, rdy, sv, so;
  logic signed [15:0] i_v, q_v;
  logic signed [15:0] gi[$];
  logic signed [15:0] gq[$];
  logic go[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  psm_src i_psm_src (.clk_i(clk), .bit_o(bit_d), .valid_o(bit_v));
  psm_mapper #(.W(16)) i_psm_mapper (.SYS_CLK_I(clk), .RST_I(rst), .MODE_I(mode),
    .BIT_I(bit_d), .BIT_VALID_I(bit_v), .BIT_READY_O(rdy), .I_O(i_v), .Q_O(q_v),
    .SYM_VALID_O(sv), .SYM_ODD_O(so));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sv === 1'b1) begin
      gi.push_back(i_v);
      gq.push_back(q_v);
      go.push_back(so);
    end
    // Ceiling far above the roughly 85 cycles the scenarios need
    if (cyc == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic signed [15:0] ei, input logic signed [15:0] eq,
    input logic eo);
    if (gi.size() == 0) begin
      cmp(16'hdead, {ei[7:0], eq[7:0]});
    end else begin
      cmp(gi.pop_front(), ei);
      cmp(gq.pop_front(), eq);
      cmp({15'h0, go.pop_front()}, {15'h0, eo});
    end
  endtask
  task automatic chk_end;
    cmp(16'(gi.size()), 16'h0);
  endtask
  task automatic start(input logic [1:0] m);
    @(negedge clk);
    rst = 1'b1;
    mode = m;
    repeat (5) @(negedge clk);
    cmp({sv, i_v[14:0]}, 16'h0);
    cmp({so, q_v[14:0]}, 16'h0);
    rst = 1'b0;
    gi.delete();
    gq.delete();
    go.delete();
  endtask
  task automatic fin;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_bpsk;
    start(psm_pkg::MODE_BPSK);
    i_psm_src.send(16'h2, 2);
    fin;
    cmp({15'h0, rdy}, 16'h1);
    chk(U, Z, 1'b0);
    chk(-U, Z, 1'b0);
    chk_end;
  endtask
  task automatic t_pi2;
    start(psm_pkg::MODE_PI2_BPSK);
    i_psm_src.send(16'hc, 4);
    fin;
    chk(U, Z, 1'b0);
    chk(Z, -U, 1'b1);
    chk(-U, Z, 1'b0);
    chk(Z, U, 1'b1);
    chk_end;
  endtask
  task automatic t_qpsk;
    start(psm_pkg::MODE_QPSK);
    i_psm_src.send(16'h9, 4);
    fin;
    chk(D, -D, 1'b0);
    chk(-D, D, 1'b0);
    chk_end;
  endtask
  task automatic t_pi4;
    start(psm_pkg::MODE_PI4_QPSK);
    i_psm_src.send(16'hb61c, 16);
    fin;
    chk(D, -D, 1'b0);
    chk(U, Z, 1'b1);
    chk(-D, D, 1'b0);
    chk(Z, -U, 1'b1);
    chk(-D, -D, 1'b0);
    chk(Z, U, 1'b1);
    chk(D, D, 1'b0);
    chk(-U, Z, 1'b1);
    chk_end;
  endtask
  task automatic t_rst;
    start(psm_pkg::MODE_PI2_BPSK);
    i_psm_src.send(16'h1, 1);
    start(psm_pkg::MODE_PI2_BPSK);
    i_psm_src.send(16'h1, 1);
    fin;
    chk(U, Z, 1'b0);
    chk_end;
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    t_bpsk;
    t_pi2;
    t_qpsk;
    t_pi4;
    t_rst;
    final_report;
  end
endmodule
`default_nettype wire
